// >>> inc/gsp_pkg.sv
`default_nettype none
package gsp_pkg;
    // Command codes of the configuration registers
    localparam logic [7:0] CMD_GROUP_BUS_CONFIG = 8'hd3;
    localparam logic [7:0] CMD_GOOD_SIGNAL_DELAY = 8'hd4;
    localparam logic [7:0] CMD_SHARED_RAMP_GAIN = 8'hd5;
    localparam logic [7:0] CMD_INDUCTANCE_VALUE = 8'hd6;
    localparam logic [7:0] CMD_FAULT_RECORD_MASK = 8'hd7;

    // Field positions of group_bus_config
    localparam int POS_SHARE_POSITION_LSB = 13;
    localparam int POS_SHARE_POSITION_MSB = 15;
    localparam int POS_RAIL_ID_LSB = 8;
    localparam int POS_RAIL_ID_MSB = 12;
    localparam int POS_PHASES_LSB = 0;
    localparam int POS_PHASES_MSB = 3;

    // Writable bits of each register; the rest read zero
    localparam logic [15:0] MASK_GROUP_BUS_CONFIG = 16'hff0f;
    localparam logic [15:0] MASK_SHARED_RAMP_GAIN = 16'h00ff;
    localparam logic [15:0] MASK_FAULT_RECORD = 16'h3fff;
    localparam logic [15:0] MASK_FULL_WORD = 16'hffff;

    // Reset values
    localparam logic [15:0] RST_GROUP_BUS_CONFIG = 16'h0000;
    localparam logic [15:0] RST_GOOD_SIGNAL_DELAY = 16'h0000;
    localparam logic [7:0] RST_SHARED_RAMP_GAIN = 8'h01;
    localparam logic [15:0] RST_INDUCTANCE_VALUE = 16'h0000;
    localparam logic [15:0] RST_FAULT_RECORD_MASK = 16'h0000;

    // Fault bit positions of fault_record_mask
    localparam int FLT_VOUT_OV = 0;
    localparam int FLT_VOUT_UV = 1;
    localparam int FLT_OVERTEMPERATURE = 2;
    localparam int FLT_UNDERTEMPERATURE = 3;
    localparam int FLT_VIN_OV = 4;
    localparam int FLT_VIN_UV = 5;
    localparam int FLT_IOUT_OC = 6;
    localparam int FLT_IOUT_UC = 7;
    localparam int FLT_AUX_MON_OV = 8;
    localparam int FLT_AUX_MON_UV = 9;
    localparam int FLT_MEM_CHECKSUM = 10;
    localparam int FLT_PROCESSOR = 11;
    localparam int FLT_PHASE_IN_RAIL = 12;
    localparam int FLT_RAIL_IN_GROUP = 13;
    localparam int NUM_FAULTS = 14;

    // Timing
    localparam int CLK_FREQ_HZ = 25000000;
    localparam int TIME_UNIT_MS = 1;
    localparam int CYCLES_PER_MS = CLK_FREQ_HZ / 1000 * TIME_UNIT_MS;
    localparam logic [12:0] OK_DELAY_MAX_MS = 13'h1388;

    typedef enum logic [1:0] {
        OK_IDLE,
        OK_WAIT,
        OK_GOOD
    } gsp_ok_state_t;
endpackage : gsp_pkg
`default_nettype wire

// >>> rtl/gsp_config_regs.sv
// Overview of operation
// - Hold five-bit rail identifier in bits 12:8.
// - Bits 15:13 give share position minus one.
// - Bits 3:0 odd codes 1..7 give phase count.
// - Delay output_ok_pin after output crosses threshold.
// - Delay capped 5000 ms, rounded to ms.
// - Hold eight-bit shared ramp gain.
// - Sharing forces shared ramp, disables fast loop.
// - After output ok, return to fast loop.
// - Sharing disables soft-off, ignores fall time.
// - Hold sixteen-bit inductance for ripple calculations.
// - Mask bit one blocks fault snapshot trigger.
// - Mask bits 0-7 map output/input/temperature faults.
// - Mask bits 8-13 map monitor/system faults.
`timescale 1ns/1ps
`default_nettype none
module gsp_config_regs
#(
    parameter int CYCLES_PER_MS = gsp_pkg::CYCLES_PER_MS
)
(
    // Clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CLK_EN_I,
    // Command port of the serial bus engine
    input wire logic [7:0] CMD_CODE_I,
    input wire logic WR_STB_I,
    input wire logic [15:0] WR_DATA_I,
    input wire logic RD_STB_I,
    output logic [15:0] RD_DATA_O,
    output logic RD_VALID_O,
    output logic CMD_UNSUPPORTED_O,
    // Analog and fault side
    input wire logic VOUT_ABOVE_ON_I,
    input wire logic [gsp_pkg::NUM_FAULTS-1:0] FAULT_EVENTS_I,
    // Control outputs
    output logic OUTPUT_OK_PIN_O,
    output logic [4:0] RAIL_IDENTIFIER_O,
    output logic [2:0] SHARE_POSITION_O,
    output logic [3:0] PHASE_COUNT_O,
    output logic CURRENT_SHARE_O,
    output logic SHARED_RAMP_MODE_O,
    output logic HIGH_BW_LOOP_O,
    output logic SOFT_OFF_ALLOWED_O,
    output logic [7:0] SHARED_RAMP_GAIN_O,
    output logic [15:0] INDUCTANCE_VALUE_O,
    output logic SNAPSHOT_REQ_O,
    output logic [gsp_pkg::NUM_FAULTS-1:0] SNAPSHOT_CAUSE_O
);
    import gsp_pkg::*;

    localparam logic [14:0] MS_TICKS = 15'(CYCLES_PER_MS - 1);

    typedef struct packed {
        logic [15:0] group_bus_config;
        logic [15:0] good_signal_delay;
        logic [7:0] shared_ramp_gain;
        logic [15:0] inductance_value;
        logic [15:0] fault_record_mask;
        logic [15:0] rd_data;
        logic rd_valid;
        logic unsupported;
        logic vout_meta;
        logic vout_sync;
        gsp_ok_state_t ok_state;
        logic [14:0] tick_cnt;
        logic [12:0] ms_left;
        logic output_ok;
        logic [NUM_FAULTS-1:0] fault_prev;
        logic snap_req;
        logic [NUM_FAULTS-1:0] snap_cause;
    } gsp_state_t;

    gsp_state_t state_r;
    gsp_state_t state_nxt;

    // Linear (5-bit exponent, 11-bit mantissa) to whole ms, rounded, capped
    function automatic logic [12:0] lin_to_ms(input logic [15:0] v);
        logic [4:0] e;
        logic [4:0] sh;
        logic [31:0] acc;
        e = v[15:11];
        sh = 5'(~e + 5'h01);
        acc = 32'h0;
        if (v[10]) // Negative delays mean no delay
        begin
            acc = 32'h0;
        end
        else if (!e[4])
        begin
            acc = {21'h0, v[10:0]} << e[3:0];
        end
        else
        begin
            acc = ({21'h0, v[10:0]} + (32'h1 << (sh - 5'h01))) >> sh;
        end
        if (acc > {19'h0, OK_DELAY_MAX_MS})
        begin
            acc = {19'h0, OK_DELAY_MAX_MS};
        end
        return acc[12:0];
    endfunction : lin_to_ms

    // Odd codes 1..7 are the only legal phase settings
    function automatic logic phases_valid(input logic [3:0] code);
        return code[0] & ~code[3];
    endfunction : phases_valid

    logic share_cfg;
    logic [NUM_FAULTS-1:0] armed_faults;

    assign share_cfg = phases_valid(state_r.group_bus_config[POS_PHASES_MSB:POS_PHASES_LSB]);

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.rd_valid = 1'b0;
        state_nxt.unsupported = 1'b0;
        state_nxt.snap_req = 1'b0;

        // Command decode; bits outside each register's mask stay zero
        if (WR_STB_I)
        begin
            case (CMD_CODE_I)
                CMD_GROUP_BUS_CONFIG:
                    state_nxt.group_bus_config = WR_DATA_I & MASK_GROUP_BUS_CONFIG;
                CMD_GOOD_SIGNAL_DELAY:
                    state_nxt.good_signal_delay = WR_DATA_I & MASK_FULL_WORD;
                CMD_SHARED_RAMP_GAIN:
                    state_nxt.shared_ramp_gain = WR_DATA_I[7:0];
                CMD_INDUCTANCE_VALUE:
                    state_nxt.inductance_value = WR_DATA_I;
                CMD_FAULT_RECORD_MASK:
                    state_nxt.fault_record_mask = WR_DATA_I & MASK_FAULT_RECORD;
                default:
                    state_nxt.unsupported = 1'b1;
            endcase
        end
        else if (RD_STB_I)
        begin
            state_nxt.rd_valid = 1'b1;
            case (CMD_CODE_I)
                CMD_GROUP_BUS_CONFIG:
                    state_nxt.rd_data = state_r.group_bus_config;
                CMD_GOOD_SIGNAL_DELAY:
                    state_nxt.rd_data = state_r.good_signal_delay;
                CMD_SHARED_RAMP_GAIN:
                    state_nxt.rd_data = {8'h00, state_r.shared_ramp_gain};
                CMD_INDUCTANCE_VALUE:
                    state_nxt.rd_data = state_r.inductance_value;
                CMD_FAULT_RECORD_MASK:
                    state_nxt.rd_data = state_r.fault_record_mask;
                default:
                begin
                    state_nxt.rd_data = 16'h0000;
                    state_nxt.rd_valid = 1'b0;
                    state_nxt.unsupported = 1'b1;
                end
            endcase
        end

        // The comparator is asynchronous to this clock
        state_nxt.vout_meta = VOUT_ABOVE_ON_I;
        state_nxt.vout_sync = state_r.vout_meta;

        // Delay is sampled at the crossing so a rewrite mid-wait has no effect
        case (state_r.ok_state)
            OK_IDLE:
            begin
                state_nxt.output_ok = 1'b0;
                if (state_r.vout_sync)
                begin
                    state_nxt.ms_left = lin_to_ms(state_r.good_signal_delay);
                    state_nxt.tick_cnt = MS_TICKS;
                    state_nxt.ok_state = OK_WAIT;
                end
            end
            OK_WAIT:
            begin
                if (!state_r.vout_sync)
                begin
                    state_nxt.ok_state = OK_IDLE;
                end
                else if (state_r.ms_left == 13'h0000)
                begin
                    state_nxt.output_ok = 1'b1;
                    state_nxt.ok_state = OK_GOOD;
                end
                else if (state_r.tick_cnt == 15'h0000)
                begin
                    state_nxt.tick_cnt = MS_TICKS;
                    state_nxt.ms_left = state_r.ms_left - 13'h0001;
                end
                else
                begin
                    state_nxt.tick_cnt = state_r.tick_cnt - 15'h0001;
                end
            end
            OK_GOOD:
            begin
                if (!state_r.vout_sync)
                begin
                    state_nxt.output_ok = 1'b0;
                    state_nxt.ok_state = OK_IDLE;
                end
            end
            default:
            begin
                state_nxt.output_ok = 1'b0;
                state_nxt.ok_state = OK_IDLE;
            end
        endcase

        // A fault triggers a snapshot only on its rising edge, so a lasting
        // fault writes memory once rather than every cycle
        state_nxt.fault_prev = FAULT_EVENTS_I;
        if (|armed_faults)
        begin
            state_nxt.snap_req = 1'b1;
            state_nxt.snap_cause = armed_faults;
        end
    end

    // Bit order follows the mask layout one to one
    assign armed_faults = FAULT_EVENTS_I & ~state_r.fault_prev
        & ~state_r.fault_record_mask[NUM_FAULTS-1:0];

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_r <= '0;
            state_r.group_bus_config <= RST_GROUP_BUS_CONFIG;
            state_r.good_signal_delay <= RST_GOOD_SIGNAL_DELAY;
            state_r.shared_ramp_gain <= RST_SHARED_RAMP_GAIN;
            state_r.inductance_value <= RST_INDUCTANCE_VALUE;
            state_r.fault_record_mask <= RST_FAULT_RECORD_MASK;
            state_r.ok_state <= OK_IDLE;
        end
        else if (CLK_EN_I)
        begin
            state_r <= state_nxt;
        end
    end

    // Register bus answers
    assign RD_DATA_O = state_r.rd_data;
    assign RD_VALID_O = state_r.rd_valid;
    assign CMD_UNSUPPORTED_O = state_r.unsupported;

    // Group identity; host keeps rail identifier equal across the group
    assign RAIL_IDENTIFIER_O = state_r.group_bus_config[POS_RAIL_ID_MSB:POS_RAIL_ID_LSB];
    assign SHARE_POSITION_O =
        state_r.group_bus_config[POS_SHARE_POSITION_MSB:POS_SHARE_POSITION_LSB];
    // Phase count is code plus one; zero while the code is not legal
    assign PHASE_COUNT_O = share_cfg ?
        state_r.group_bus_config[POS_PHASES_MSB:POS_PHASES_LSB] + 4'h1 : 4'h0;
    assign CURRENT_SHARE_O = share_cfg;

    // Ramp and loop control
    assign SHARED_RAMP_MODE_O = share_cfg & ~state_r.output_ok;
    assign HIGH_BW_LOOP_O = ~share_cfg | state_r.output_ok;
    assign SOFT_OFF_ALLOWED_O = ~share_cfg;
    assign SHARED_RAMP_GAIN_O = state_r.shared_ramp_gain;
    assign INDUCTANCE_VALUE_O = state_r.inductance_value;

    assign OUTPUT_OK_PIN_O = state_r.output_ok;
    assign SNAPSHOT_REQ_O = state_r.snap_req;
    assign SNAPSHOT_CAUSE_O = state_r.snap_cause;
endmodule : gsp_config_regs
`default_nettype wire

// >>> verification/gsp_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gsp_regs_sva
#(
    parameter int CYCLES_PER_MS = 25000
)
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CLK_EN_I,
    // Command port
    input wire logic [7:0] CMD_CODE_I,
    input wire logic WR_STB_I,
    input wire logic [15:0] WR_DATA_I,
    input wire logic RD_STB_I,
    input wire logic RD_VALID_O,
    input wire logic CMD_UNSUPPORTED_O,
    // Analog and fault side
    input wire logic VOUT_ABOVE_ON_I,
    input wire logic [13:0] FAULT_EVENTS_I,
    // Control outputs
    input wire logic OUTPUT_OK_PIN_O,
    input wire logic [4:0] RAIL_IDENTIFIER_O,
    input wire logic [2:0] SHARE_POSITION_O,
    input wire logic [3:0] PHASE_COUNT_O,
    input wire logic CURRENT_SHARE_O,
    input wire logic SHARED_RAMP_MODE_O,
    input wire logic HIGH_BW_LOOP_O,
    input wire logic SOFT_OFF_ALLOWED_O,
    input wire logic SNAPSHOT_REQ_O,
    input wire logic [13:0] SNAPSHOT_CAUSE_O
);
    logic [15:0] wd_r;
    always_ff @(posedge SYS_CLK_I)
    begin
        wd_r <= WR_DATA_I;
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_cfg_wr;
        CLK_EN_I && WR_STB_I && CMD_CODE_I == 8'hd3;
    endsequence
    sequence s_low;
        (CLK_EN_I && !VOUT_ABOVE_ON_I) [*4];
    endsequence
    property p_rd_ok;
        CLK_EN_I && RD_STB_I && !WR_STB_I && CMD_CODE_I inside {[8'hd3:8'hd7]} |=> RD_VALID_O;
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("read not answered");
    property p_unmapped;
        CLK_EN_I && (WR_STB_I || RD_STB_I) && !(CMD_CODE_I inside {[8'hd3:8'hd7]})
            |=> CMD_UNSUPPORTED_O && !RD_VALID_O;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped code accepted");
    property p_rail;
        s_cfg_wr |=> RAIL_IDENTIFIER_O == wd_r[12:8] && SHARE_POSITION_O == wd_r[15:13];
    endproperty
    a_rail: assert property (p_rail) else $error("group fields wrong");
    property p_phase;
        s_cfg_wr |=> CURRENT_SHARE_O == (wd_r[0] && !wd_r[3])
            && PHASE_COUNT_O == ((wd_r[0] && !wd_r[3]) ? wd_r[3:0] + 4'h1 : 4'h0);
    endproperty
    a_phase: assert property (p_phase) else $error("phase decode wrong");
    property p_ramp;
        CURRENT_SHARE_O && !OUTPUT_OK_PIN_O |-> SHARED_RAMP_MODE_O && !HIGH_BW_LOOP_O;
    endproperty
    a_ramp: assert property (p_ramp) else $error("shared ramp not used");
    property p_loop;
        OUTPUT_OK_PIN_O |-> HIGH_BW_LOOP_O && !SHARED_RAMP_MODE_O;
    endproperty
    a_loop: assert property (p_loop) else $error("fast loop not restored");
    property p_soft;
        SOFT_OFF_ALLOWED_O == !CURRENT_SHARE_O;
    endproperty
    a_soft: assert property (p_soft) else $error("soft off while sharing");
    // Two synchroniser stages and the state register lie between pin and output
    property p_ok_rise;
        $rose(OUTPUT_OK_PIN_O) |-> $past(VOUT_ABOVE_ON_I, 3);
    endproperty
    a_ok_rise: assert property (p_ok_rise) else $error("output ok without level");
    property p_ok_drop;
        s_low |=> !OUTPUT_OK_PIN_O;
    endproperty
    a_ok_drop: assert property (p_ok_drop) else $error("output ok held");
    property p_snap;
        SNAPSHOT_REQ_O |-> SNAPSHOT_CAUSE_O != 14'h0
            && (SNAPSHOT_CAUSE_O & ~$past(FAULT_EVENTS_I)) == 14'h0
            && (SNAPSHOT_CAUSE_O & $past(FAULT_EVENTS_I, 2)) == 14'h0;
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot cause wrong");
endmodule : gsp_regs_sva
bind gsp_config_regs gsp_regs_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_sva (.*);
`default_nettype wire

// >>> verification/gsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsp_host_model
(
    // Clock
    input wire logic clk_i,
    // Command port
    output logic [7:0] cmd_o,
    output logic wr_o,
    output logic [15:0] wd_o,
    output logic rd_o
);
    initial
    begin
        cmd_o = 8'h00;
        wr_o = 1'b0;
        wd_o = 16'h0000;
        rd_o = 1'b0;
    end
    // Idle gap models a slow host; returns at the taking edge
    task automatic acc(input logic [7:0] c, input logic w, input logic [15:0] d, input int gap);
        repeat (gap + 1) @(posedge clk_i);
        cmd_o <= c;
        wd_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // Released lines must not keep showing the old value
        cmd_o <= ~c;
        wd_o <= ~d;
    endtask : acc
endmodule : gsp_host_model
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gsp_pkg::*;
    localparam int CPM = 8;
    logic SYS_CLK_I, RST_I, CLK_EN_I, WR_STB_I, RD_STB_I, RD_VALID_O, CMD_UNSUPPORTED_O;
    logic VOUT_ABOVE_ON_I, OUTPUT_OK_PIN_O, CURRENT_SHARE_O, SHARED_RAMP_MODE_O;
    logic HIGH_BW_LOOP_O, SOFT_OFF_ALLOWED_O, SNAPSHOT_REQ_O;
    logic [7:0] CMD_CODE_I, SHARED_RAMP_GAIN_O;
    logic [15:0] WR_DATA_I, RD_DATA_O, INDUCTANCE_VALUE_O;
    logic [NUM_FAULTS-1:0] FAULT_EVENTS_I, SNAPSHOT_CAUSE_O;
    logic [4:0] RAIL_IDENTIFIER_O;
    logic [2:0] SHARE_POSITION_O;
    logic [3:0] PHASE_COUNT_O;
    int n_fail = 0;
    int checks = 0;
    gsp_config_regs #(.CYCLES_PER_MS(CPM)) i_dut (.*);
    gsp_host_model i_host (.clk_i(SYS_CLK_I), .cmd_o(CMD_CODE_I), .wr_o(WR_STB_I),
        .wd_o(WR_DATA_I), .rd_o(RD_STB_I));
    initial
    begin
        SYS_CLK_I = 1'b0;
        forever #20 SYS_CLK_I = ~SYS_CLK_I;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    function automatic logic [15:0] msk(input logic [7:0] c);
        case (c)
            CMD_GROUP_BUS_CONFIG: return 16'hff0f;
            CMD_SHARED_RAMP_GAIN: return 16'h00ff;
            CMD_FAULT_RECORD_MASK: return 16'h3fff;
            default: return 16'hffff;
        endcase
    endfunction : msk
    function automatic logic [3:0] phc(input logic [3:0] v);
        return (v[0] && !v[3]) ? v + 4'h1 : 4'h0;
    endfunction : phc
    task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
        i_host.acc(c, 1'b0, 16'h0000, 0);
        #1;
        chk("rd_valid", 16'h1, 16'(RD_VALID_O));
        chk("rd_data", e, RD_DATA_O);
    endtask : rdchk
    initial
    begin
        logic [7:0] c;
        logic [15:0] d;
        logic [13:0] m;
        int n;
        RST_I = 1'b1;
        CLK_EN_I = 1'b1;
        VOUT_ABOVE_ON_I = 1'b0;
        FAULT_EVENTS_I = '0;
        void'($urandom(86));
        repeat (6) @(posedge SYS_CLK_I);
        RST_I <= 1'b0;
        #1;
        chk("gain", 16'h1, 16'(SHARED_RAMP_GAIN_O));
        for (int r = 0; r < 5; r++)
            rdchk(8'hd3 + 8'(r), (r == 2) ? 16'h1 : 16'h0);
        for (int k = 0; k < 40; k++)
        begin
            c = (k < 16) ? 8'hd3 : 8'hd3 + 8'($urandom_range(0, 4));
            d = 16'($urandom);
            if (k < 16)
                d[3:0] = 4'(k);
            i_host.acc(c, 1'b1, d, k % 3);
            #1;
            if (c == CMD_GROUP_BUS_CONFIG)
            begin
                chk("rail", 16'(d[12:8]), 16'(RAIL_IDENTIFIER_O));
                chk("pos", 16'(d[15:13]), 16'(SHARE_POSITION_O));
                chk("phases", 16'(phc(d[3:0])), 16'(PHASE_COUNT_O));
            end
            if (c == CMD_SHARED_RAMP_GAIN)
                chk("gain", d & 16'hff, 16'(SHARED_RAMP_GAIN_O));
            if (c == CMD_INDUCTANCE_VALUE)
                chk("ind", d, INDUCTANCE_VALUE_O);
            rdchk(c, d & msk(c));
        end
        for (int i = 0; i < 3; i++)
        begin
            c = (i == 0) ? 8'hd2 : (i == 1) ? 8'hd8 : 8'h00;
            i_host.acc(c, i[0], 16'hffff, 0);
            #1;
            chk("unsupported", 16'h1, 16'(CMD_UNSUPPORTED_O));
        end
        i_host.acc(CMD_GROUP_BUS_CONFIG, 1'b1, 16'h0a01, 0);
        i_host.acc(CMD_GOOD_SIGNAL_DELAY, 1'b1, 16'hf805, 0);
        #1;
        chk("shared_ramp", 16'h1, 16'(SHARED_RAMP_MODE_O));
        @(posedge SYS_CLK_I);
        VOUT_ABOVE_ON_I <= 1'b1;
        for (n = 0; n < 200 && OUTPUT_OK_PIN_O !== 1'b1; n++)
        begin
            @(posedge SYS_CLK_I);
            #1;
        end
        chk("ok_delay", 16'h1, 16'(n >= 3 * CPM && n <= 3 * CPM + 8));
        if (n == 200)
            wrap_up();
        chk("fast_loop", 16'h1, 16'(HIGH_BW_LOOP_O && !SHARED_RAMP_MODE_O));
        chk("soft", 16'h0, 16'(SOFT_OFF_ALLOWED_O));
        @(posedge SYS_CLK_I);
        VOUT_ABOVE_ON_I <= 1'b0;
        repeat (5) @(posedge SYS_CLK_I);
        #1;
        chk("ok_drop", 16'h0, 16'(OUTPUT_OK_PIN_O));
        m = 14'($urandom);
        for (int r = 0; r < 2; r++)
        begin
            i_host.acc(CMD_FAULT_RECORD_MASK, 1'b1, 16'(m), 0);
            FAULT_EVENTS_I <= '0;
            for (int i = 0; i < NUM_FAULTS; i++)
            begin
                @(posedge SYS_CLK_I);
                FAULT_EVENTS_I <= FAULT_EVENTS_I | (14'h1 << i);
                @(posedge SYS_CLK_I);
                #1;
                chk("snap_req", 16'(!m[i]), 16'(SNAPSHOT_REQ_O));
                if (!m[i])
                    chk("cause", 16'h1 << i, 16'(SNAPSHOT_CAUSE_O));
            end
            m = ~m;
        end
        // Enable low freezes every register, so a write then is lost
        i_host.acc(CMD_INDUCTANCE_VALUE, 1'b1, 16'h1234, 0);
        CLK_EN_I <= 1'b0;
        i_host.acc(CMD_INDUCTANCE_VALUE, 1'b1, 16'hedcb, 0);
        #1;
        chk("ind_frozen", 16'h1234, INDUCTANCE_VALUE_O);
        @(posedge SYS_CLK_I);
        CLK_EN_I <= 1'b1;
        rdchk(CMD_INDUCTANCE_VALUE, 16'h1234);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
